// ### rci_cfg.svh
// Address map, field positions, reset values and limits of the indicator block.
`ifndef RCI_CFG_SVH
`define RCI_CFG_SVH
`define RCI_ADR_CTRL 8'h00
`define RCI_ADR_STATUS 8'h04
`define RCI_ADR_ARC 8'h08
`define RCI_ADR_DEAD 8'h0C
`define RCI_ADR_RECLAIM 8'h10
`define RCI_ADR_LOCKOUT 8'h14
`define RCI_CTRL_MODE 0
`define RCI_CTRL_USE_EXT 1
`define RCI_CTRL_SHOT_LSB 2
`define RCI_CTRL_SHOT_MSB 4
`define RCI_CTRL_MRST 8
`define RCI_CTRL_RST 5'h04
`define RCI_ARC_RST 24'h0000C8
`define RCI_DEAD_RST 24'h0003E8
`define RCI_RECLAIM_RST 24'h0007D0
`define RCI_LOCKOUT_RST 24'h0007D0
`define RCI_SHOT_ONE 3'h1
`define RCI_SHOT_MAX 3'h5
`define RCI_IND_EN 0
`define RCI_IND_DIS 1
`define RCI_IND_ACT 2
`define RCI_IND_RUN 3
`define RCI_IND_DONE 4
`define RCI_IND_FINAL 5
`define RCI_IND_DEAD 6
`define RCI_IND_ARC 7
`define RCI_IND_RCL 8
`define RCI_IND_RDY 9
`define RCI_IND_POST 10
`define RCI_IND_INH 11
`define RCI_IND_LCK 12
`define RCI_IND_REQ_LSB 13
`define RCI_IND_REQ_MSB 17
`define RCI_IND_SHOT_LSB 18
`define RCI_IND_SHOT_MSB 22
`endif

// ### rci_pkg.sv
// Types shared by the indicator block and its timer.
package rci_pkg;
  typedef logic [23:0] rci_time_t;
  typedef logic [22:0] rci_ind_t;
  typedef logic [31:0] rci_word_t;
  typedef enum logic [2:0] {
    RCI_INHIBIT = 3'b000,
    RCI_READY = 3'b001,
    RCI_ARC = 3'b010,
    RCI_DEAD = 3'b011,
    RCI_RECLAIM = 3'b100,
    RCI_LOCKOUT = 3'b101,
    RCI_LOCKED = 3'b110
  } rci_state_e;
endpackage

// ### rci_tmr_if.sv
// Load and status signals between the sequencer and its interval timer.
interface rci_tmr_if;
  logic load;
  rci_pkg::rci_time_t value;
  logic busy;
  modport ctl (output load, output value, input busy);
  modport tmr (input load, input value, output busy);
endinterface

// ### rci_sync.sv
// Two-stage synchroniser for a group of pin inputs.
module rci_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ### rci_timer.sv
// Down-counter that times the arcing, dead, reclaim and lockout intervals.
module rci_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  rci_tmr_if.tmr t
);
  import rci_pkg::*;
  rci_time_t cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (t.load) begin
      cnt_reg <= t.value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 24'h000001;
    end
  end
  assign t.busy = (cnt_reg != '0);
endmodule

// ### rci_top.sv
// Reclosing sequencer with status indications and a Wishbone register port.
`include "rci_cfg.svh"

// Behaviour
// - Only indications leave the block; no breaker open or close command.
// - Enabled indication follows the enabled state of the function.
// - Disabled indication when external enable is used and that input is low.
// - Sequence-active and dead-interval indications while dead time runs.
// - Each request indication only while its request's shot executes.
// - Running indication while the sequencer is in running mode.
// - Five shot indications, each while its numbered shot executes.
// - Sequence-done after reclose following last shot, during reclaim wait.
// - Final-trip indication once the final trip has been issued.
// - Arcing indication while the arcing interval is counted.
// - Reclaim indication while the reclaim interval is counted.
// - Ready indication while a sequence can start on a fault.
// - Post-success lockout indication on a fault within the lockout interval.
// - During post-success lockout no new sequence; go locked instead.
// - Inhibit indication while the sequencer is in inhibit mode.
// - Locked indication while the sequencer is in locked mode.
// - Request one has highest priority, request five lowest.
// - Critical request moves the sequencer straight to locked, except from inhibit, which it leaves for ready first when enabled and locks a cycle later.
// - Without external enable in use, the function counts as enabled whenever the mode bit is set.
module rci_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire rci_pkg::rci_word_t wb_dat_i,
  output rci_pkg::rci_word_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_enable_input_i,
  input wire logic [4:0] reclose_request_i,
  input wire logic critical_lock_request_i,
  input wire logic breaker_closed_i,
  output logic recloser_enabled_ind_o,
  output logic recloser_disabled_ind_o,
  output logic sequence_active_ind_o,
  output logic [4:0] request_shot_ind_o,
  output logic running_state_ind_o,
  output logic [4:0] shot_active_ind_o,
  output logic sequence_done_ind_o,
  output logic final_trip_ind_o,
  output logic dead_interval_ind_o,
  output logic arcing_interval_ind_o,
  output logic reclaim_interval_ind_o,
  output logic ready_state_ind_o,
  output logic post_success_lockout_ind_o,
  output logic inhibit_state_ind_o,
  output logic locked_state_ind_o
);
  import rci_pkg::*;

  logic [7:0] pins_s;
  logic [4:0] req_s;
  logic ext_s;
  logic crit_s;
  logic closed_s;
  rci_sync #(.W(8)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({breaker_closed_i, critical_lock_request_i,
          external_enable_input_i, reclose_request_i}),
    .q_o(pins_s)
  );
  assign req_s = pins_s[4:0];
  assign ext_s = pins_s[5];
  assign crit_s = pins_s[6];
  assign closed_s = pins_s[7];

  rci_tmr_if tmr ();
  rci_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(tmr.tmr)
  );

  // Register port.
  logic [4:0] ctrl_reg;
  rci_time_t arc_reg;
  rci_time_t dead_reg;
  rci_time_t reclaim_reg;
  rci_time_t lockout_reg;
  logic ack_reg;
  rci_word_t dat_reg;
  logic mrst_reg;
  logic hit;
  logic wr;
  logic [7:0] adr;
  rci_word_t wmask;
  rci_word_t rd_next;
  rci_ind_t ind_reg;
  rci_ind_t ind_next;

  function automatic rci_word_t merge(rci_word_t old_v, rci_word_t m);
    merge = (old_v & ~m) | (wb_dat_i & m);
  endfunction

  assign hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = hit & wb_we_i & (wb_adr_i[31:8] == 24'h000000);
  assign adr = wb_adr_i[7:0];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `RCI_CTRL_RST;
      arc_reg <= `RCI_ARC_RST;
      dead_reg <= `RCI_DEAD_RST;
      reclaim_reg <= `RCI_RECLAIM_RST;
      lockout_reg <= `RCI_LOCKOUT_RST;
    end else if (wr) begin
      case (adr)
        `RCI_ADR_CTRL: ctrl_reg <= 5'(merge({27'h0, ctrl_reg}, wmask));
        `RCI_ADR_ARC: arc_reg <= 24'(merge({8'h00, arc_reg}, wmask));
        `RCI_ADR_DEAD: dead_reg <= 24'(merge({8'h00, dead_reg}, wmask));
        `RCI_ADR_RECLAIM: begin
          reclaim_reg <= 24'(merge({8'h00, reclaim_reg}, wmask));
        end
        `RCI_ADR_LOCKOUT: begin
          lockout_reg <= 24'(merge({8'h00, lockout_reg}, wmask));
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // The manual reset bit is a command: it acts once and always reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mrst_reg <= 1'b0;
    end else begin
      mrst_reg <= wr & (adr == `RCI_ADR_CTRL) & wb_sel_i[1]
                  & wb_dat_i[`RCI_CTRL_MRST];
    end
  end

  always_comb begin
    rd_next = 32'h00000000;
    if (wb_adr_i[31:8] == 24'h000000) begin
      case (adr)
        `RCI_ADR_CTRL: rd_next = {27'h0, ctrl_reg};
        `RCI_ADR_STATUS: rd_next = {9'h000, ind_reg};
        `RCI_ADR_ARC: rd_next = {8'h00, arc_reg};
        `RCI_ADR_DEAD: rd_next = {8'h00, dead_reg};
        `RCI_ADR_RECLAIM: rd_next = {8'h00, reclaim_reg};
        `RCI_ADR_LOCKOUT: rd_next = {8'h00, lockout_reg};
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h00000000;
    end else if (hit) begin
      dat_reg <= rd_next;
    end
  end
  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;

  // Sequencer.
  rci_state_e state_reg;
  rci_state_e state_next;
  logic [2:0] shot_reg;
  logic [2:0] shot_next;
  logic [4:0] sel_reg;
  logic [4:0] sel_next;
  logic final_reg;
  logic post_reg;
  logic enabled;
  logic [2:0] shot_lim;
  logic [2:0] shot_fld;
  logic [4:0] req_pick;
  logic any_req;
  logic set_final;
  logic set_post;

  assign enabled = ctrl_reg[`RCI_CTRL_MODE]
                   & (~ctrl_reg[`RCI_CTRL_USE_EXT] | ext_s);
  assign shot_fld = ctrl_reg[`RCI_CTRL_SHOT_MSB:`RCI_CTRL_SHOT_LSB];
  assign shot_lim = (shot_fld > `RCI_SHOT_MAX) ? `RCI_SHOT_MAX : shot_fld;
  assign req_pick = req_s & (~req_s + 5'h01);
  assign any_req = (req_s != 5'h00);
  assign set_final = (state_reg == RCI_RECLAIM) & any_req
                     & (shot_reg >= shot_lim);
  assign set_post = (state_reg == RCI_LOCKOUT) & any_req;

  always_comb begin
    state_next = state_reg;
    shot_next = shot_reg;
    sel_next = sel_reg;
    tmr.load = 1'b0;
    tmr.value = arc_reg;
    if (!enabled) begin
      state_next = RCI_INHIBIT;
    end else if (crit_s && state_reg != RCI_INHIBIT) begin
      state_next = RCI_LOCKED;
    end else begin
      case (state_reg)
        RCI_INHIBIT: state_next = RCI_READY;
        RCI_READY: begin
          if (any_req) begin
            state_next = RCI_ARC;
            shot_next = `RCI_SHOT_ONE;
            sel_next = req_pick;
            tmr.load = 1'b1;
          end
        end
        RCI_ARC: begin
          if (!tmr.busy) begin
            state_next = RCI_DEAD;
            tmr.value = dead_reg;
            tmr.load = 1'b1;
          end
        end
        RCI_DEAD: begin
          // The reclose itself belongs to the object control function.
          if (!tmr.busy && closed_s) begin
            state_next = RCI_RECLAIM;
            tmr.value = reclaim_reg;
            tmr.load = 1'b1;
          end
        end
        RCI_RECLAIM: begin
          if (set_final) begin
            state_next = RCI_LOCKED;
          end else if (any_req) begin
            state_next = RCI_ARC;
            shot_next = shot_reg + 3'h1;
            sel_next = req_pick;
            tmr.load = 1'b1;
          end else if (!tmr.busy) begin
            state_next = RCI_LOCKOUT;
            tmr.value = lockout_reg;
            tmr.load = 1'b1;
          end
        end
        RCI_LOCKOUT: begin
          if (set_post) begin
            state_next = RCI_LOCKED;
          end else if (!tmr.busy) begin
            state_next = RCI_READY;
          end
        end
        RCI_LOCKED: begin
          if (mrst_reg) begin
            state_next = RCI_READY;
          end
        end
        default: state_next = RCI_INHIBIT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= RCI_INHIBIT;
      shot_reg <= `RCI_SHOT_ONE;
      sel_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      shot_reg <= shot_next;
      sel_reg <= sel_next;
    end
  end

  // Set beats the manual reset so a trip in the same cycle is never lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      final_reg <= 1'b0;
      post_reg <= 1'b0;
    end else begin
      if (enabled && !crit_s && set_final) begin
        final_reg <= 1'b1;
      end else if (mrst_reg) begin
        final_reg <= 1'b0;
      end
      if (enabled && !crit_s && set_post) begin
        post_reg <= 1'b1;
      end else if (mrst_reg || state_reg != RCI_LOCKED) begin
        post_reg <= post_reg & (state_reg == RCI_LOCKOUT);
      end
    end
  end

  // Indications are registered, so each shows the state one cycle late.
  logic run;
  logic [4:0] shot_oh;
  assign run = (state_reg == RCI_ARC) | (state_reg == RCI_DEAD)
               | (state_reg == RCI_RECLAIM);
  assign shot_oh = 5'h01 << (shot_reg - 3'h1);

  always_comb begin
    ind_next = '0;
    ind_next[`RCI_IND_EN] = enabled;
    ind_next[`RCI_IND_DIS] = ctrl_reg[`RCI_CTRL_USE_EXT] & ~ext_s;
    ind_next[`RCI_IND_ACT] = (state_reg == RCI_DEAD) & tmr.busy;
    ind_next[`RCI_IND_DEAD] = (state_reg == RCI_DEAD) & tmr.busy;
    ind_next[`RCI_IND_RUN] = run;
    ind_next[`RCI_IND_DONE] = (state_reg == RCI_RECLAIM)
                              & (shot_reg >= shot_lim);
    ind_next[`RCI_IND_FINAL] = final_reg;
    ind_next[`RCI_IND_ARC] = (state_reg == RCI_ARC) & tmr.busy;
    ind_next[`RCI_IND_RCL] = (state_reg == RCI_RECLAIM) & tmr.busy;
    ind_next[`RCI_IND_RDY] = (state_reg == RCI_READY);
    ind_next[`RCI_IND_POST] = post_reg;
    ind_next[`RCI_IND_INH] = (state_reg == RCI_INHIBIT);
    ind_next[`RCI_IND_LCK] = (state_reg == RCI_LOCKED);
    ind_next[`RCI_IND_REQ_MSB:`RCI_IND_REQ_LSB] =
      run ? sel_reg : 5'h00;
    ind_next[`RCI_IND_SHOT_MSB:`RCI_IND_SHOT_LSB] =
      run ? shot_oh : 5'h00;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_reg <= '0;
    end else begin
      ind_reg <= ind_next;
    end
  end

  // Nothing here drives the breaker; every output below is an indication.
  assign recloser_enabled_ind_o = ind_reg[`RCI_IND_EN];
  assign recloser_disabled_ind_o = ind_reg[`RCI_IND_DIS];
  assign sequence_active_ind_o = ind_reg[`RCI_IND_ACT];
  assign running_state_ind_o = ind_reg[`RCI_IND_RUN];
  assign sequence_done_ind_o = ind_reg[`RCI_IND_DONE];
  assign final_trip_ind_o = ind_reg[`RCI_IND_FINAL];
  assign dead_interval_ind_o = ind_reg[`RCI_IND_DEAD];
  assign arcing_interval_ind_o = ind_reg[`RCI_IND_ARC];
  assign reclaim_interval_ind_o = ind_reg[`RCI_IND_RCL];
  assign ready_state_ind_o = ind_reg[`RCI_IND_RDY];
  assign post_success_lockout_ind_o = ind_reg[`RCI_IND_POST];
  assign inhibit_state_ind_o = ind_reg[`RCI_IND_INH];
  assign locked_state_ind_o = ind_reg[`RCI_IND_LCK];
  assign request_shot_ind_o = ind_reg[`RCI_IND_REQ_MSB:`RCI_IND_REQ_LSB];
  assign shot_active_ind_o = ind_reg[`RCI_IND_SHOT_MSB:`RCI_IND_SHOT_LSB];

  sequence s_start;
    state_reg == RCI_READY && any_req && enabled && !crit_s;
  endsequence
  sequence s_last_fault;
    set_final && enabled && !crit_s;
  endsequence

  AST_CRIT_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (crit_s && enabled && state_reg != RCI_INHIBIT)
    |=> state_reg == RCI_LOCKED ##1 locked_state_ind_o)
    else $error("Critical request did not lock.");
  AST_ENABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_reg[`RCI_CTRL_MODE] && !ctrl_reg[`RCI_CTRL_USE_EXT])
    |=> recloser_enabled_ind_o && !recloser_disabled_ind_o)
    else $error("Function not enabled without external input.");
  AST_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    recloser_disabled_ind_o == $past(ctrl_reg[`RCI_CTRL_USE_EXT] && !ext_s))
    else $error("Disabled indication wrong.");
  AST_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start |=> (state_reg == RCI_ARC) && $onehot(sel_reg)
    && ((sel_reg - 5'h01) & $past(req_s)) == 5'h00
    ##1 request_shot_ind_o == sel_reg && shot_active_ind_o == 5'h01)
    else $error("Wrong request picked at shot start.");
  AST_FINAL: assert property (@(posedge clk_i) disable iff (rst_i)
    s_last_fault |=> final_reg && state_reg == RCI_LOCKED ##1 final_trip_ind_o)
    else $error("Final trip not indicated.");
  AST_POST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    post_success_lockout_ind_o |-> locked_state_ind_o
    || $past(state_reg) == RCI_INHIBIT)
    else $error("Post-success lockout without locked state.");
  AST_ONE_SHOT: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(shot_active_ind_o) && $onehot0(request_shot_ind_o))
    else $error("More than one shot indicated.");
  AST_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0({inhibit_state_ind_o, locked_state_ind_o,
              ready_state_ind_o, running_state_ind_o}))
    else $error("State indications overlap.");
  AST_DEAD: assert property (@(posedge clk_i) disable iff (rst_i)
    dead_interval_ind_o == sequence_active_ind_o
    and (dead_interval_ind_o |-> $past(state_reg) == RCI_DEAD))
    else $error("Dead interval indications disagree.");
  AST_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    running_state_ind_o == $past(run) and (!running_state_ind_o
    |-> shot_active_ind_o == 5'h00))
    else $error("Running indication wrong.");
endmodule

// ### rci_breaker_model.sv
// Breaker and object control stand-in that drives the breaker status pin.
module rci_breaker_model #(
  parameter int CLOSE_DLY = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic arc_i,
  input wire logic dead_i,
  output logic closed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Only this side opens and closes the breaker; the block just watches.
  // The trip lands during arcing time, the reclose after a delay in dead time.
  always @(posedge clk_i) begin
    if (rst_i) begin
      closed_o <= 1'b1;
      cnt <= 0;
    end else if (arc_i) begin
      closed_o <= 1'b0;
      cnt <= 0;
    end else if (dead_i && !closed_o) begin
      cnt <= cnt + 1;
      if (cnt >= CLOSE_DLY - 1) closed_o <= 1'b1;
    end
  end
endmodule

// ### testbench.sv
// Self-checking testbench of the reclosing indicator block.
`include "rci_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rci_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, ext_en, crit, brk;
  logic [31:0] wb_adr;
  logic [3:0] wb_sel;
  rci_word_t wb_dat, wb_dat_o;
  logic wb_ack_o;
  logic [4:0] req, req_ind, shot_ind;
  logic en, dis, act, run, done, fin, dead, arc, rcl, rdy, post, inh, lck;
  rci_ind_t ind;
  int error_cnt = 0;
  int num_checks = 0;
  assign ind = {shot_ind, req_ind, lck, inh, post, rdy, rcl, arc, dead, fin,
    done, run, act, dis, en};
  rci_top rci_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_enable_input_i(ext_en), .reclose_request_i(req),
    .critical_lock_request_i(crit), .breaker_closed_i(brk),
    .recloser_enabled_ind_o(en), .recloser_disabled_ind_o(dis),
    .sequence_active_ind_o(act), .request_shot_ind_o(req_ind),
    .running_state_ind_o(run), .shot_active_ind_o(shot_ind),
    .sequence_done_ind_o(done), .final_trip_ind_o(fin),
    .dead_interval_ind_o(dead), .arcing_interval_ind_o(arc),
    .reclaim_interval_ind_o(rcl), .ready_state_ind_o(rdy),
    .post_success_lockout_ind_o(post), .inhibit_state_ind_o(inh),
    .locked_state_ind_o(lck));
  rci_breaker_model rci_breaker_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .arc_i(arc), .dead_i(dead), .closed_o(brk));
  always #2.5 clk_i = ~clk_i;
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
    input rci_word_t wd, output rci_word_t rd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {24'h000000, adr};
    wb_dat <= wd;
    wb_sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (n >= 20) check({31'h0, wb_ack_o}, 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input rci_word_t d);
    rci_word_t r;
    wb_cycle(1'b1, adr, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input rci_word_t exp);
    rci_word_t r;
    wb_cycle(1'b0, adr, 32'h0, r);
    check(r, exp);
  endtask
  // Bounded wait; a wait that runs out is itself a mismatch.
  task automatic wait_ind(input int idx, input logic val);
    int n;
    n = 0;
    while (ind[idx] !== val && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300) check({31'h0, ind[idx]}, {31'h0, val});
  endtask
  task automatic pins(input logic [4:0] r, input logic c, input logic e);
    @(posedge clk_i);
    req <= r;
    crit <= c;
    ext_en <= e;
  endtask
  task automatic t_reset();
    repeat (3) @(posedge clk_i);
    check(ind, 32'h1 << `RCI_IND_INH);
    rd_chk(`RCI_ADR_CTRL, 32'h4);
    rd_chk(`RCI_ADR_ARC, 32'hC8);
    rd_chk(`RCI_ADR_DEAD, 32'h3E8);
    rd_chk(`RCI_ADR_RECLAIM, 32'h7D0);
    rd_chk(`RCI_ADR_LOCKOUT, 32'h7D0);
    wr(`RCI_ADR_STATUS, 32'hFFFFFFFF);
    rd_chk(`RCI_ADR_STATUS, 32'h1 << `RCI_IND_INH);
    wr(8'h18, 32'hFFFFFFFF);
    rd_chk(8'h18, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_enable();
    wr(`RCI_ADR_CTRL, 32'h9);
    wait_ind(`RCI_IND_RDY, 1'b1);
    check(ind, 32'h1 << `RCI_IND_EN | 32'h1 << `RCI_IND_RDY);
    wr(`RCI_ADR_CTRL, 32'hB);
    wait_ind(`RCI_IND_DIS, 1'b1);
    wait_ind(`RCI_IND_INH, 1'b1);
    check({en, rdy}, 32'h0);
    pins(5'h00, 1'b0, 1'b1);
    wait_ind(`RCI_IND_EN, 1'b1);
    check(dis, 32'h0);
    wr(`RCI_ADR_CTRL, 32'h9);
    pins(5'h00, 1'b0, 1'b0);
    repeat (8) @(posedge clk_i);
    check({en, dis, rdy}, 32'h5);
    $display("t_enable done");
  endtask
  task automatic t_seq();
    wr(`RCI_ADR_ARC, 32'h8);
    wr(`RCI_ADR_DEAD, 32'h8);
    wr(`RCI_ADR_RECLAIM, 32'h14);
    wr(`RCI_ADR_LOCKOUT, 32'h14);
    pins(5'h16, 1'b0, 1'b0);
    wait_ind(`RCI_IND_ARC, 1'b1);
    check(ind[22:13], {5'h01, 5'h02});
    check({run, rdy}, 32'h2);
    pins(5'h00, 1'b0, 1'b0);
    wait_ind(`RCI_IND_DEAD, 1'b1);
    check(act, 32'h1);
    wait_ind(`RCI_IND_RCL, 1'b1);
    check(done, 32'h0);
    pins(5'h10, 1'b0, 1'b0);
    wait_ind(`RCI_IND_SHOT_LSB + 1, 1'b1);
    check(ind[22:13], {5'h02, 5'h10});
    pins(5'h00, 1'b0, 1'b0);
    wait_ind(`RCI_IND_DONE, 1'b1);
    check(rcl, 32'h1);
    pins(5'h01, 1'b0, 1'b0);
    wait_ind(`RCI_IND_FINAL, 1'b1);
    wait_ind(`RCI_IND_LCK, 1'b1);
    pins(5'h00, 1'b0, 1'b0);
    wr(`RCI_ADR_CTRL, 32'h109);
    wait_ind(`RCI_IND_RDY, 1'b1);
    check({fin, lck}, 32'h0);
    $display("t_seq done");
  endtask
  task automatic t_post();
    wr(`RCI_ADR_CTRL, 32'h5);
    pins(5'h08, 1'b0, 1'b0);
    // The fault must clear before reclaim, or the single shot ends in a trip.
    wait_ind(`RCI_IND_ARC, 1'b1);
    pins(5'h00, 1'b0, 1'b0);
    wait_ind(`RCI_IND_RCL, 1'b1);
    check({done, req_ind}, {26'h0, 1'b1, 5'h08});
    wait_ind(`RCI_IND_RCL, 1'b0);
    pins(5'h01, 1'b0, 1'b0);
    wait_ind(`RCI_IND_POST, 1'b1);
    wait_ind(`RCI_IND_LCK, 1'b1);
    check({arc, shot_ind}, 32'h0);
    pins(5'h00, 1'b0, 1'b0);
    wr(`RCI_ADR_CTRL, 32'h105);
    wait_ind(`RCI_IND_RDY, 1'b1);
    check(post, 32'h0);
    $display("t_post done");
  endtask
  task automatic t_crit();
    pins(5'h00, 1'b1, 1'b0);
    wait_ind(`RCI_IND_LCK, 1'b1);
    check(arc, 32'h0);
    pins(5'h00, 1'b0, 1'b0);
    wr(`RCI_ADR_CTRL, 32'h105);
    wait_ind(`RCI_IND_RDY, 1'b1);
    wr(`RCI_ADR_CTRL, 32'h4);
    wait_ind(`RCI_IND_INH, 1'b1);
    pins(5'h00, 1'b1, 1'b0);
    repeat (8) @(posedge clk_i);
    check({lck, inh}, 32'h1);
    pins(5'h00, 1'b0, 1'b0);
    $display("t_crit done");
  endtask
  // Exclusive indications are watched on every cycle of the run.
  always @(posedge clk_i) begin
    if (!rst_i) begin
      check($onehot0(shot_ind), 32'h1);
      check($onehot0(req_ind), 32'h1);
      check($onehot0({inh, lck, rdy, run}), 32'h1);
    end
  end
  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
    summarize();
  end
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, ext_en, crit} = 5'h00;
    wb_adr = 32'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    req = 5'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_enable();
    t_seq();
    t_post();
    t_crit();
    summarize();
  end
endmodule
